/* File: verif/rlm_props.sv */
// assertion checker for the repeater layer management top module
// assumes one clock domain and the defines header on the include path
`timescale 1ns/1ns
`include "rlm_defines.vh"
module rlm_props #(
	parameter SELFTEST_CYCLES = 1000
) (
	// clock and reset
	input wire REF_CLK,
	input wire RST_N,
	// management bus
	input wire [11:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	input wire AVS_WAITREQUEST,
	// failure reports
	input wire HEALTH_KNOWN,
	input wire UNIT_LEVEL_FAILURE,
	input wire GROUP_LEVEL_FAILURE,
	input wire PORT_LEVEL_FAILURE,
	input wire UNSPECIFIED_FAILURE,
	// core control and notifications
	input wire CORE_FORCE_START,
	input wire CORE_TX_INHIBIT,
	input wire RESET_NOTIFICATION,
	input wire HEALTH_CHANGE_NOTIFICATION,
	input wire [2:0] NOTIFY_HEALTH_STATE
);
	reg [15:0] fcnt_reg;
	// a reset action request as the bus carries it
	wire go = AVS_WRITE && AVS_ADDRESS == `RLM_OFS_CTRL && AVS_WRITEDATA[0] && AVS_BYTEENABLE[0];
	// expected health: fixed priority, ok only when nothing fails
	wire [2:0] hexp = UNIT_LEVEL_FAILURE ? `RLM_HEALTH_UNIT : GROUP_LEVEL_FAILURE ? `RLM_HEALTH_GROUP :
		PORT_LEVEL_FAILURE ? `RLM_HEALTH_PORT : UNSPECIFIED_FAILURE ? `RLM_HEALTH_UNSPEC :
		HEALTH_KNOWN ? `RLM_HEALTH_OK : `RLM_HEALTH_OTHER;
	// counts the forced-start span; a repetition cannot hold a parameter
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			fcnt_reg <= 16'h0000;
		end else begin
			fcnt_reg <= CORE_FORCE_START ? fcnt_reg + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	wait_read_a: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST[*2] ##1 !AVS_WAITREQUEST)
		else $error("read wait states wrong");
	idle_nowait_a: assert property (!AVS_READ |-> !AVS_WAITREQUEST)
		else $error("wait without a read");
	start_cause_a: assert property ($rose(CORE_FORCE_START) |-> $past(go))
		else $error("forced start without request");
	req_start_a: assert property (go && !CORE_FORCE_START && !$past(CORE_FORCE_START) |=> CORE_FORCE_START)
		else $error("request did not force start");
	force_len_a: assert property ($fell(CORE_FORCE_START) |-> fcnt_reg == SELFTEST_CYCLES + 1)
		else $error("self-test span wrong");
	inhibit_match_a: assert property (CORE_TX_INHIBIT == CORE_FORCE_START)
		else $error("transmit inhibit not with test");
	notify_after_a: assert property ($fell(CORE_FORCE_START) |=> RESET_NOTIFICATION)
		else $error("no reset notification");
	rn_pulse_a: assert property (RESET_NOTIFICATION |=> !RESET_NOTIFICATION)
		else $error("reset notification too long");
	health_note_a: assert property ($past(RST_N) && $changed(hexp) |=>
		HEALTH_CHANGE_NOTIFICATION && NOTIFY_HEALTH_STATE == $past(hexp))
		else $error("health change missed");
	quiet_health_a: assert property ($past(RST_N) && !$changed(hexp) |=> !HEALTH_CHANGE_NOTIFICATION)
		else $error("spurious health change");
	cover property ($fell(AVS_WAITREQUEST) && AVS_READ);
	cover property ($fell(CORE_FORCE_START));
	cover property (HEALTH_CHANGE_NOTIFICATION);
endmodule
bind rlm_top rlm_props #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) rlm_props_i (
	.REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .HEALTH_KNOWN(HEALTH_KNOWN), .UNIT_LEVEL_FAILURE(UNIT_LEVEL_FAILURE),
	.GROUP_LEVEL_FAILURE(GROUP_LEVEL_FAILURE), .PORT_LEVEL_FAILURE(PORT_LEVEL_FAILURE),
	.UNSPECIFIED_FAILURE(UNSPECIFIED_FAILURE), .CORE_FORCE_START(CORE_FORCE_START),
	.CORE_TX_INHIBIT(CORE_TX_INHIBIT), .RESET_NOTIFICATION(RESET_NOTIFICATION),
	.HEALTH_CHANGE_NOTIFICATION(HEALTH_CHANGE_NOTIFICATION), .NOTIFY_HEALTH_STATE(NOTIFY_HEALTH_STATE)
);

/* File: verif/rlm_top_test.sv */
// self-checking bench for the repeater layer management block
// assumes the design and checker are compiled first, defines header on the include path
`timescale 1ns/1ns
`include "rlm_defines.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module rlm_top_test;
	localparam [31:0] TC = 32'h0000_0042; // arbitrary type code
	logic REF_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [11:0] AVS_ADDRESS = 12'h000;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
	logic [4:0] hin = 5'h10; // known, unit, group, port, unspecified
	logic [7:0] grp = 8'hA5;
	logic [3:0] ev = 4'h0; // txcol, from one-port-left, jam, multi
	logic [31:0] AVS_READDATA, got;
	logic AVS_WAITREQUEST, force_start, tx_inhibit, rst_note, hc_note;
	logic [2:0] note_health;
	// read data of the 10M and 1000M variants, taken at the same edge as the main read
	wire [31:0] alt_rdata [2];
	logic [31:0] alt_got [2];
	logic [4:0] hv [7] = '{5'h00, 5'h1F, 5'h17, 5'h13, 5'h11, 5'h06, 5'h10};
	logic [2:0] he [7] = '{`RLM_HEALTH_OTHER, `RLM_HEALTH_UNIT, `RLM_HEALTH_GROUP, `RLM_HEALTH_PORT,
		`RLM_HEALTH_UNSPEC, `RLM_HEALTH_GROUP, `RLM_HEALTH_OK};
	int err_count = 0;
	int num_checks = 0;
	rlm_top #(.GROUP_CAP(8), .TYPE_CODE(TC), .SELFTEST_CYCLES(4)) rlm_top_i (
		.REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .HEALTH_KNOWN(hin[4]),
		.UNIT_LEVEL_FAILURE(hin[3]), .GROUP_LEVEL_FAILURE(hin[2]), .PORT_LEVEL_FAILURE(hin[1]),
		.UNSPECIFIED_FAILURE(hin[0]), .GROUP_PRESENT(grp), .TXCOL_ENTRY(ev[3]),
		.TXCOL_FROM_ONE_PORT_LEFT(ev[2]), .JAM_ENTRY(ev[1]), .JAM_MULTI_ACTIVITY(ev[0]),
		.CORE_FORCE_START(force_start), .CORE_TX_INHIBIT(tx_inhibit), .RESET_NOTIFICATION(rst_note),
		.HEALTH_CHANGE_NOTIFICATION(hc_note), .NOTIFY_HEALTH_STATE(note_health)
	);
	// the other two variants share every input; only their collision counts are compared
	for (genvar v = 0; v < 2; v++) begin : g_var
		rlm_top #(.GROUP_CAP(8), .VARIANT((v == 0) ? 2'h0 : 2'h2), .TYPE_CODE(TC), .SELFTEST_CYCLES(4)) rlm_top_i (
			.REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
			.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
			.AVS_READDATA(alt_rdata[v]), .AVS_WAITREQUEST(), .HEALTH_KNOWN(hin[4]),
			.UNIT_LEVEL_FAILURE(hin[3]), .GROUP_LEVEL_FAILURE(hin[2]), .PORT_LEVEL_FAILURE(hin[1]),
			.UNSPECIFIED_FAILURE(hin[0]), .GROUP_PRESENT(grp), .TXCOL_ENTRY(ev[3]),
			.TXCOL_FROM_ONE_PORT_LEFT(ev[2]), .JAM_ENTRY(ev[1]), .JAM_MULTI_ACTIVITY(ev[0]),
			.CORE_FORCE_START(), .CORE_TX_INHIBIT(), .RESET_NOTIFICATION(),
			.HEALTH_CHANGE_NOTIFICATION(), .NOTIFY_HEALTH_STATE()
		);
	end
	// 250 MHz
	always #2 REF_CLK = ~REF_CLK;
	// bus read: hold until waitrequest is seen low, take data at that edge
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge REF_CLK);
		AVS_ADDRESS <= a;
		AVS_READ <= 1'b1;
		do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
		d = AVS_READDATA;
		alt_got[0] = alt_rdata[0];
		alt_got[1] = alt_rdata[1];
		AVS_READ <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= 1'b1;
		do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
		AVS_WRITE <= 1'b0;
	endtask
	task automatic crd(input logic [11:0] a, input logic [31:0] e, input string n);
		rd(a, got);
		`CHK(n, e, got)
	endtask
	// one-cycle core event, low for a cycle after it
	task automatic pulse(input logic [3:0] v);
		@(posedge REF_CLK);
		ev <= v;
		@(posedge REF_CLK);
		ev <= 4'h0;
	endtask
	task wrap_up();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// the whole run needs well under a thousand cycles
	initial begin
		#20000;
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge REF_CLK);
		RST_N <= 1'b1;
		crd(`RLM_OFS_NOTIFY, 32'h0000_0001, "power-on note");
		wr(`RLM_OFS_NOTIFY, 32'h0000_0003);
		crd(`RLM_OFS_NOTIFY, 32'h0000_0000, "note clear");
		wr(`RLM_OFS_TYPE, 32'h0000_0000);
		crd(`RLM_OFS_TYPE, TC, "type");
		crd(`RLM_OFS_GRP_CAP, 32'h0000_0008, "capacity");
		crd(`RLM_OFS_GRP_MAP, 32'h0000_00A5, "map");
		grp <= 8'h81;
		crd(`RLM_OFS_GRP_MAP, 32'h0000_0081, "map ends");
		crd(12'h030, 32'h0000_0000, "unmapped");
		for (int i = 0; i < 7; i++) begin
			hin <= hv[i];
			// every step changes the encoded health, so each one must pulse the notification
			repeat (2) @(posedge REF_CLK);
			`CHK("health pulse", 1'b1, hc_note)
			crd(`RLM_OFS_HEALTH, {29'h0, he[i]}, "health");
		end
		crd(`RLM_OFS_NOTIFY, 32'h0000_0002, "health note");
		crd(`RLM_OFS_NOTIFY_HEALTH, {29'h0, `RLM_HEALTH_OK}, "last health");
		wr(`RLM_OFS_NOTIFY, 32'h0000_0003);
		wr(12'h400, 32'h0000_0041);
		wr(12'h7F8, 32'h0000_0007);
		wr(12'h800, 32'h0000_0000);
		wr(12'hBFC, 32'h0000_00FF);
		wr(`RLM_OFS_TEXT_LEN, 32'h0000_00FF);
		crd(12'h7F8, 32'h0000_003F, "text sub");
		crd(`RLM_OFS_TEXT_LEN, 32'h0000_00FF, "text len");
		crd(12'hBFC, 32'h0000_00FF, "data top");
		crd(12'h800, 32'h0000_0000, "data low");
		pulse(4'h3);
		pulse(4'h3);
		pulse(4'h3);
		pulse(4'h2);
		pulse(4'h8);
		pulse(4'hC);
		wr(`RLM_OFS_TXCOL, 32'h0000_0000);
		crd(`RLM_OFS_TXCOL, 32'h0000_0003, "collisions");
		`CHK("collisions 10M", 32'h0000_0001, alt_got[0])
		`CHK("collisions 1000M", 32'h0000_0004, alt_got[1])
		wr(`RLM_OFS_CTRL, 32'h0000_0001);
		rd(`RLM_OFS_CTRL, got);
		`CHK("busy", 1'b1, got[1])
		`CHK("force start", 1'b1, force_start)
		`CHK("tx inhibit", 1'b1, tx_inhibit)
		for (int k = 0; k < 40 && rst_note !== 1'b1; k++) @(posedge REF_CLK);
		`CHK("reset note", 1'b1, rst_note)
		`CHK("start released", 1'b0, force_start)
		`CHK("note health", `RLM_HEALTH_OK, note_health)
		crd(12'h400, 32'h0000_0041, "text kept");
		crd(`RLM_OFS_TXCOL, 32'h0000_0003, "count kept");
		crd(`RLM_OFS_NOTIFY, 32'h0000_0001, "reset sticky");
		wrap_up();
	end
endmodule

/* File: verilog/rlm_defines.vh */
// constants for the repeater layer management block
// assumes inclusion by bare name from every design file that needs it
`ifndef RLM_DEFINES_VH
`define RLM_DEFINES_VH

// register byte offsets on the management bus
`define RLM_OFS_TYPE 12'h000
`define RLM_OFS_HEALTH 12'h004
`define RLM_OFS_GRP_CAP 12'h008
`define RLM_OFS_GRP_MAP 12'h00C
`define RLM_OFS_TXCOL 12'h010
`define RLM_OFS_CTRL 12'h014
`define RLM_OFS_NOTIFY 12'h018
`define RLM_OFS_TEXT_LEN 12'h01C
`define RLM_OFS_DATA_LEN 12'h020
`define RLM_OFS_NOTIFY_HEALTH 12'h024

// address regions: registers, then text and data buffer windows of one byte per aligned word
`define RLM_REGION_REGS 2'b00
`define RLM_REGION_TEXT 2'b01
`define RLM_REGION_DATA 2'b10

// health state encodings
`define RLM_HEALTH_OTHER 3'h1
`define RLM_HEALTH_OK 3'h2
`define RLM_HEALTH_UNIT 3'h3
`define RLM_HEALTH_GROUP 3'h4
`define RLM_HEALTH_PORT 3'h5
`define RLM_HEALTH_UNSPEC 3'h6

// field positions
`define RLM_CTRL_RESET_BIT 0
`define RLM_CTRL_BUSY_BIT 1
`define RLM_NOTIFY_RESET_BIT 0
`define RLM_NOTIFY_HEALTH_BIT 1

// repeater variants
`define RLM_VARIANT_10M 2'h0
`define RLM_VARIANT_100M 2'h1
`define RLM_VARIANT_1000M 2'h2

// reset values
`define RLM_RST_TEXT_LEN 8'h00
`define RLM_RST_DATA_LEN 8'h00
`define RLM_RST_TXCOL 32'h0000_0000

// timing: self-test length in ns at a 4 ns clock
`define RLM_CLK_PERIOD_NS 4
`define RLM_SELFTEST_NS 4000
`define RLM_SELFTEST_CYCLES ((`RLM_SELFTEST_NS + `RLM_CLK_PERIOD_NS - 1) / `RLM_CLK_PERIOD_NS)

// printable character range and the stand-in for others
`define RLM_PRINT_LO 8'h20
`define RLM_PRINT_HI 8'h7E
`define RLM_PRINT_SUB 8'h3F

`endif

/* File: verilog/rlm_mem.v */
// small byte memory for the health text and health data buffers
// assumes one clock; read data appear from a register one edge after the address
`timescale 1ns/1ns
module rlm_mem #(
	parameter AW = 8,
	parameter DW = 8
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// access port
	input wire [AW-1:0] addr,
	input wire we,
	input wire [DW-1:0] wdata,
	output reg [DW-1:0] rdata_reg
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// write array, registered read; array itself needs no reset
	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= {DW{1'b0}};
		end else begin
			rdata_reg <= mem[addr];
		end
	end
endmodule

/* File: verilog/rlm_top.v */
// repeater layer management: health, group map, collision counter, reset action
// assumes a single clock, core events synchronous one-cycle pulses, Avalon-MM master
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`include "rlm_defines.vh"

module rlm_top #(
	parameter GROUP_CAP = 8,
	parameter [1:0] VARIANT = 2'h1,
	parameter [31:0] TYPE_CODE = 32'h0000_001B, // arbitrary value
	parameter SELFTEST_CYCLES = `RLM_SELFTEST_CYCLES
) (
	// clock and reset
	input wire REF_CLK,
	input wire RST_N,
	// management bus
	input wire [11:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	output reg [31:0] AVS_READDATA,
	output wire AVS_WAITREQUEST,
	// failure reports from the repeater
	input wire HEALTH_KNOWN,
	input wire UNIT_LEVEL_FAILURE,
	input wire GROUP_LEVEL_FAILURE,
	input wire PORT_LEVEL_FAILURE,
	input wire UNSPECIFIED_FAILURE,
	input wire [GROUP_CAP-1:0] GROUP_PRESENT,
	// core state machine events
	input wire TXCOL_ENTRY,
	input wire TXCOL_FROM_ONE_PORT_LEFT,
	input wire JAM_ENTRY,
	input wire JAM_MULTI_ACTIVITY,
	// core control
	output reg CORE_FORCE_START,
	output reg CORE_TX_INHIBIT,
	// notifications
	output reg RESET_NOTIFICATION,
	output reg HEALTH_CHANGE_NOTIFICATION,
	output reg [2:0] NOTIFY_HEALTH_STATE
);
	// reset action states
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_START = 4'b0010;
	localparam [3:0] ST_TEST = 4'b0100;
	localparam [3:0] ST_NOTIFY = 4'b1000;
	localparam CNT_W = 16;

	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [CNT_W-1:0] test_cnt_reg;
	reg [2:0] health_reg;
	reg primed_reg;
	reg por_pending_reg;
	reg [31:0] txcol_reg;
	reg [GROUP_CAP-1:0] group_map_reg;
	reg [7:0] text_len_reg;
	reg [7:0] data_len_reg;
	reg note_reset_reg;
	reg note_health_reg;
	reg [1:0] rd_cnt_reg;
	reg [31:0] reg_rdata_reg;
	reg [1:0] rd_region_reg;
	wire [2:0] health_now;
	wire [1:0] region;
	wire [11:0] reg_ofs;
	wire wr_acc;
	wire rd_done;
	wire col_event;
	wire reset_req;
	wire notify_fire;
	wire health_change;
	wire text_we;
	wire data_we;
	wire [7:0] text_rdata;
	wire [7:0] data_rdata;
	wire [7:0] text_wbyte;

	// fixed priority: unit over group over port over unspecified
	function [2:0] health_encode;
		input known;
		input f_unit;
		input f_group;
		input f_port;
		input f_unspec;
		begin
			if (f_unit) begin
				health_encode = `RLM_HEALTH_UNIT;
			end else if (f_group) begin
				health_encode = `RLM_HEALTH_GROUP;
			end else if (f_port) begin
				health_encode = `RLM_HEALTH_PORT;
			end else if (f_unspec) begin
				health_encode = `RLM_HEALTH_UNSPEC;
			end else if (known) begin
				health_encode = `RLM_HEALTH_OK;
			end else begin
				health_encode = `RLM_HEALTH_OTHER;
			end
		end
	endfunction

	// non-printable bytes are replaced so the text stays readable
	function [7:0] printable;
		input [7:0] c;
		begin
			if (c >= `RLM_PRINT_LO && c <= `RLM_PRINT_HI) begin
				printable = c;
			end else begin
				printable = `RLM_PRINT_SUB;
			end
		end
	endfunction

	// bus decode
	assign region = AVS_ADDRESS[11:10];
	assign reg_ofs = {AVS_ADDRESS[11:2], 2'b00};
	assign wr_acc = AVS_WRITE && !AVS_READ;
	assign rd_done = AVS_READ && (rd_cnt_reg == 2'd2);
	// reads wait two edges so that buffer data come out of a register
	assign AVS_WAITREQUEST = AVS_READ && !rd_done;

	// write to control register with the reset bit starts the reset action
	assign reset_req = wr_acc && (region == `RLM_REGION_REGS) && (reg_ofs == `RLM_OFS_CTRL) &&
		AVS_BYTEENABLE[0] && AVS_WRITEDATA[`RLM_CTRL_RESET_BIT];

	// health recomputed every cycle from the failure inputs
	assign health_now = health_encode(HEALTH_KNOWN, UNIT_LEVEL_FAILURE, GROUP_LEVEL_FAILURE,
		PORT_LEVEL_FAILURE, UNSPECIFIED_FAILURE);

	// variant selects which core event counts as a transmit collision
	generate
		if (VARIANT == `RLM_VARIANT_10M) begin : g_col10
			assign col_event = TXCOL_ENTRY && !TXCOL_FROM_ONE_PORT_LEFT;
		end else if (VARIANT == `RLM_VARIANT_100M) begin : g_col100
			assign col_event = JAM_ENTRY && JAM_MULTI_ACTIVITY;
		end else begin : g_col1000
			assign col_event = JAM_ENTRY;
		end
	endgenerate

	// health change only after the first post-reset sample, so power-up is silent
	assign health_change = primed_reg && (health_now != health_reg);
	assign notify_fire = (state_reg == ST_NOTIFY) || por_pending_reg;

	// buffer writes, text filtered to printable characters
	assign text_wbyte = printable(AVS_WRITEDATA[7:0]);
	assign text_we = wr_acc && (region == `RLM_REGION_TEXT) && AVS_BYTEENABLE[0];
	assign data_we = wr_acc && (region == `RLM_REGION_DATA) && AVS_BYTEENABLE[0];

	rlm_mem #(.AW(8), .DW(8)) u_text (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.addr(AVS_ADDRESS[9:2]),
		.we(text_we),
		.wdata(text_wbyte),
		.rdata_reg(text_rdata)
	);

	rlm_mem #(.AW(8), .DW(8)) u_data (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.addr(AVS_ADDRESS[9:2]),
		.we(data_we),
		.wdata(AVS_WRITEDATA[7:0]),
		.rdata_reg(data_rdata)
	);

	// reset action sequencing
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (reset_req) begin
					state_next = ST_START;
				end
			end
			ST_START: begin
				state_next = ST_TEST;
			end
			ST_TEST: begin
				if (test_cnt_reg == SELFTEST_CYCLES[CNT_W-1:0] - 16'h0001) begin
					state_next = ST_NOTIFY;
				end
			end
			ST_NOTIFY: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// state register, self-test counter and core controls
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= ST_IDLE;
			test_cnt_reg <= 16'h0000;
			CORE_FORCE_START <= 1'b0;
			CORE_TX_INHIBIT <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_TEST) begin
				test_cnt_reg <= test_cnt_reg + 16'h0001;
			end else begin
				test_cnt_reg <= 16'h0000;
			end
			// core held in its start state for the whole self-test
			CORE_FORCE_START <= (state_next == ST_START) || (state_next == ST_TEST);
			// transmit inhibited so the test puts nothing on any segment
			CORE_TX_INHIBIT <= (state_next == ST_START) || (state_next == ST_TEST);
		end
	end

	// health tracking and notification pulses
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			health_reg <= `RLM_HEALTH_OTHER;
			primed_reg <= 1'b0;
			por_pending_reg <= 1'b1;
			group_map_reg <= {GROUP_CAP{1'b0}};
			RESET_NOTIFICATION <= 1'b0;
			HEALTH_CHANGE_NOTIFICATION <= 1'b0;
			NOTIFY_HEALTH_STATE <= `RLM_HEALTH_OTHER;
		end else begin
			health_reg <= health_now;
			primed_reg <= 1'b1;
			por_pending_reg <= 1'b0;
			// bit i stands for group i+1; width equals the capacity
			group_map_reg <= GROUP_PRESENT;
			RESET_NOTIFICATION <= notify_fire;
			HEALTH_CHANGE_NOTIFICATION <= health_change;
			if (notify_fire || health_change) begin
				NOTIFY_HEALTH_STATE <= health_now;
			end
		end
	end

	// transmit collision counter: only power-on clears it, wraps at the top
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			txcol_reg <= `RLM_RST_TXCOL;
		end else if (col_event) begin
			// 32 bits wrap after hours even at 75000 per second
			txcol_reg <= txcol_reg + 32'h0000_0001;
		end
	end

	// software registers; management state survives the self-test
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			text_len_reg <= `RLM_RST_TEXT_LEN;
			data_len_reg <= `RLM_RST_DATA_LEN;
			note_reset_reg <= 1'b0;
			note_health_reg <= 1'b0;
		end else begin
			if (wr_acc && region == `RLM_REGION_REGS && AVS_BYTEENABLE[0]) begin
				if (reg_ofs == `RLM_OFS_TEXT_LEN) begin
					text_len_reg <= AVS_WRITEDATA[7:0];
				end
				if (reg_ofs == `RLM_OFS_DATA_LEN) begin
					data_len_reg <= AVS_WRITEDATA[7:0];
				end
			end
			// sticky flags: write one clears, a new event in the same cycle wins
			if (notify_fire) begin
				note_reset_reg <= 1'b1;
			end else if (wr_acc && region == `RLM_REGION_REGS && reg_ofs == `RLM_OFS_NOTIFY &&
				AVS_BYTEENABLE[0] && AVS_WRITEDATA[`RLM_NOTIFY_RESET_BIT]) begin
				note_reset_reg <= 1'b0;
			end
			if (health_change) begin
				note_health_reg <= 1'b1;
			end else if (wr_acc && region == `RLM_REGION_REGS && reg_ofs == `RLM_OFS_NOTIFY &&
				AVS_BYTEENABLE[0] && AVS_WRITEDATA[`RLM_NOTIFY_HEALTH_BIT]) begin
				note_health_reg <= 1'b0;
			end
		end
	end

	// read pipeline: edge 0 captures register data, region and buffer data, edge 1 output
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_cnt_reg <= 2'd0;
			reg_rdata_reg <= 32'h0000_0000;
			rd_region_reg <= 2'b00;
			AVS_READDATA <= 32'h0000_0000;
		end else begin
			if (AVS_READ && !rd_done) begin
				rd_cnt_reg <= rd_cnt_reg + 2'd1;
			end else begin
				rd_cnt_reg <= 2'd0;
			end
			if (AVS_READ && rd_cnt_reg == 2'd0) begin
				rd_region_reg <= region;
				case (reg_ofs)
					`RLM_OFS_TYPE: reg_rdata_reg <= TYPE_CODE;
					`RLM_OFS_HEALTH: reg_rdata_reg <= {29'h0000_0000, health_reg};
					`RLM_OFS_GRP_CAP: reg_rdata_reg <= GROUP_CAP;
					`RLM_OFS_GRP_MAP: reg_rdata_reg <= {{(32-GROUP_CAP){1'b0}}, group_map_reg};
					`RLM_OFS_TXCOL: reg_rdata_reg <= txcol_reg;
					`RLM_OFS_CTRL: reg_rdata_reg <= {30'h0000_0000, state_reg != ST_IDLE, 1'b0};
					`RLM_OFS_NOTIFY: reg_rdata_reg <= {30'h0000_0000, note_health_reg, note_reset_reg};
					`RLM_OFS_TEXT_LEN: reg_rdata_reg <= {24'h00_0000, text_len_reg};
					`RLM_OFS_DATA_LEN: reg_rdata_reg <= {24'h00_0000, data_len_reg};
					`RLM_OFS_NOTIFY_HEALTH: reg_rdata_reg <= {29'h0000_0000, NOTIFY_HEALTH_STATE};
					default: reg_rdata_reg <= 32'h0000_0000;
				endcase
			end
			if (AVS_READ && rd_cnt_reg == 2'd1) begin
				case (rd_region_reg)
					`RLM_REGION_REGS: AVS_READDATA <= reg_rdata_reg;
					`RLM_REGION_TEXT: AVS_READDATA <= {24'h00_0000, text_rdata};
					`RLM_REGION_DATA: AVS_READDATA <= {24'h00_0000, data_rdata};
					default: AVS_READDATA <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule
